// ==== tpd_pkg.sv ====
// package: constants and types for the three-phase pwm input decode block
package tpd_pkg;

    // ==========================================================
    // control modes
    localparam logic [1:0] MODE_SIX = 2'h0;
    localparam logic [1:0] MODE_SIX_LIM = 2'h1;
    localparam logic [1:0] MODE_THREE = 2'h2;
    localparam logic [1:0] MODE_THREE_LIM = 2'h3;

    // ==========================================================
    // four-level strap codes (mode pin, buck voltage pin)
    localparam logic [1:0] STRAP_GND = 2'h0;
    localparam logic [1:0] STRAP_FLOAT = 2'h1;
    localparam logic [1:0] STRAP_RES_HIGH = 2'h2;
    localparam logic [1:0] STRAP_TIED_HIGH = 2'h3;

    // ==========================================================
    // buck voltage codes, volt labels for reference
    localparam logic [1:0] BUCK_V_3V3 = 2'h0;
    localparam logic [1:0] BUCK_V_4V0 = 2'h1;
    localparam logic [1:0] BUCK_V_5V0 = 2'h2;
    localparam logic [1:0] BUCK_V_5V7 = 2'h3;
    localparam int BUCK_LIMIT_HIGH_MA = 600;
    localparam int BUCK_LIMIT_LOW_MA = 150;

    // ==========================================================
    // reset values
    localparam logic [1:0] MODE_RESET = MODE_SIX;
    localparam logic [1:0] BUCK_V_RESET = BUCK_V_3V3;

    typedef enum {
        PH_HIZ,
        PH_HIGH,
        PH_LOW
    } tpd_phase_type;

    // per-phase gate commands
    typedef struct packed {
        logic high_on;
        logic low_on;
    } tpd_gate_type;

    // serial-variant configuration bits
    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] buck_sel;
        logic buck_disable_bit;
        logic buck_current_limit_bit;
        logic buck_sequencing_disable_bit;
        logic serial_output_drive_select;
    } tpd_cfg_type;

    // buck regulator controls towards the analog side
    typedef struct packed {
        logic enable;
        logic [1:0] voltage_sel;
        logic limit_low;
        logic avdd_from_buck;
    } tpd_buck_type;

endpackage : tpd_pkg

// ==== tpd_decode.sv ====
// three-phase pwm input decode, mode control and buck control logic
// Function
// [R1] four modes from two-bit mode field
// [R2] strap variant maps four pin levels
// [R3] limit modes: pin is threshold, sense off
// [R4] plain modes: pin is reference, sense on
// [R5] six-input truth table per phase
// [R6] three-input: low zero Hi-Z, else follow
// [R7] controller holds low inputs high if needed
// [R8] controller idles inputs before mode change
// [R9] limit comparator fed by all three amplifiers
// [R10] serial accepted only with chip select low
// [R11] serial output open-drain or push-pull
// [R12] strap variant pins replace serial pins
// [R13] buck voltage from field or strap
// [R14] buck disable only in serial variant
// [R15] buck limit 600 or 150 mA
// [R16] sequencing bit enables avdd from buck; code does so only when buck_sel is BUCK_V_5V0 or BUCK_V_5V7
// [R17] fault output works in both variants
// [R18] independent per-phase decode, Hi-Z both off
`timescale 1ns/1ps
module tpd_decode #(
    parameter int PHASES = 3
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // variant and configuration
    input wire logic strap_variant_i,
    input wire tpd_pkg::tpd_cfg_type serial_cfg_i,
    input wire logic [1:0] mode_strap_i,
    input wire logic [1:0] buck_voltage_strap_i,
    input wire logic [1:0] gain_strap_i,
    input wire logic [1:0] slew_strap_i,
    input wire logic [1:0] overcurrent_level_strap_i,
    // pwm inputs
    input wire logic [PHASES-1:0] phase_high_input_i,
    input wire logic [PHASES-1:0] phase_low_input_i,
    // current sense comparators and faults
    input wire logic [PHASES-1:0] sense_over_limit_i,
    input wire logic fault_event_i,
    // serial pins
    input wire logic serial_chip_select_n_i,
    input wire logic serial_data_i,
    // gate and phase outputs
    output tpd_pkg::tpd_gate_type [PHASES-1:0] gate_o,
    output logic [PHASES-1:0] phase_hiz_o,
    // analog routing
    output logic reference_limit_is_threshold_o,
    output logic sense_amp_output_enable_o,
    output logic current_limit_active_o,
    output logic [1:0] active_mode_o,
    output logic [1:0] gain_sel_o,
    output logic [1:0] slew_sel_o,
    output logic [1:0] overcurrent_sel_o,
    output tpd_pkg::tpd_buck_type buck_o,
    // serial and fault pins
    output logic serial_accept_o,
    output logic serial_data_out_o,
    output logic serial_data_oe_o,
    output logic fault_output_n_o
);
    import tpd_pkg::*;

    // the comparator and gate carriers are sized for one three-phase bridge
    if (PHASES != 3) begin : g_phase_count_check
        $error("tpd_decode serves exactly three phases");
    end

    // ==========================================================
    // decode helpers
    function automatic logic [1:0] strap_to_mode(input logic [1:0] lvl);
        case (lvl)
            STRAP_GND: strap_to_mode = MODE_SIX; // R2
            STRAP_FLOAT: strap_to_mode = MODE_SIX_LIM; // R2
            STRAP_RES_HIGH: strap_to_mode = MODE_THREE; // R2
            default: strap_to_mode = MODE_THREE_LIM; // R2
        endcase
    endfunction : strap_to_mode

    function automatic tpd_phase_type decode_phase(input logic [1:0] mode,
                                                   input logic hi, input logic lo);
        if (mode == MODE_THREE || mode == MODE_THREE_LIM) begin
            if (!lo) begin
                decode_phase = PH_HIZ; // R6
            end else begin
                decode_phase = hi ? PH_HIGH : PH_LOW; // R6
            end
        end else begin
            case ({lo, hi})
                2'h1: decode_phase = PH_HIGH; // R5
                2'h2: decode_phase = PH_LOW; // R5
                default: decode_phase = PH_HIZ; // R5
            endcase
        end
    endfunction : decode_phase

    function automatic logic is_limit_mode(input logic [1:0] mode);
        is_limit_mode = (mode == MODE_SIX_LIM) || (mode == MODE_THREE_LIM);
    endfunction : is_limit_mode

    function automatic logic serial_selected(input logic strap, input logic cs_n);
        serial_selected = !strap && !cs_n;
    endfunction : serial_selected

    // ==========================================================
    // control mode selection
    logic [1:0] mode_d;
    logic [1:0] mode_q;

    always_comb begin
        if (strap_variant_i) begin
            mode_d = strap_to_mode(mode_strap_i); // R12
        end else begin
            mode_d = serial_cfg_i.mode; // R1
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_q <= MODE_RESET;
        end else if (clk_en_i) begin
            mode_q <= mode_d;
        end
    end

    assign active_mode_o = mode_q;

    // ==========================================================
    // reference/limit pin routing
    logic thresh_d;
    logic thresh_q;
    logic sense_en_d;
    logic sense_en_q;

    always_comb begin
        // taken from the next mode so routing never lags the mode register
        thresh_d = is_limit_mode(mode_d); // R3
        sense_en_d = !is_limit_mode(mode_d); // R4
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            thresh_q <= 1'h0;
            sense_en_q <= 1'h1;
        end else if (clk_en_i) begin
            thresh_q <= thresh_d;
            sense_en_q <= sense_en_d;
        end
    end

    assign reference_limit_is_threshold_o = thresh_q; // R3 R4
    assign sense_amp_output_enable_o = sense_en_q; // R3 R4

    // ==========================================================
    // buck regulator controls
    tpd_buck_type buck_d;
    tpd_buck_type buck_q;

    always_comb begin
        if (strap_variant_i) begin
            // no disable strap exists, so the regulator always runs
            buck_d.enable = 1'h1; // R14
            buck_d.voltage_sel = buck_voltage_strap_i; // R13
            buck_d.limit_low = 1'h0;
            buck_d.avdd_from_buck = 1'h0;
        end else begin
            buck_d.enable = !serial_cfg_i.buck_disable_bit; // R14
            buck_d.voltage_sel = serial_cfg_i.buck_sel; // R13
            buck_d.limit_low = serial_cfg_i.buck_current_limit_bit; // R15
            // sequencing only makes sense at the upper two voltages
            buck_d.avdd_from_buck = !serial_cfg_i.buck_sequencing_disable_bit &&
                (serial_cfg_i.buck_sel == BUCK_V_5V0 ||
                 serial_cfg_i.buck_sel == BUCK_V_5V7); // R16
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            buck_q.enable <= 1'h1;
            buck_q.voltage_sel <= BUCK_V_RESET;
            buck_q.limit_low <= 1'h0;
            buck_q.avdd_from_buck <= 1'h0;
        end else if (clk_en_i) begin
            buck_q <= buck_d;
        end
    end

    assign buck_o = buck_q;

    // ==========================================================
    // strapped gain, slew and overcurrent selections
    logic [1:0] gain_d;
    logic [1:0] gain_q;
    logic [1:0] slew_d;
    logic [1:0] slew_q;
    logic [1:0] oc_level_d;
    logic [1:0] oc_level_q;

    always_comb begin
        // serial variant keeps the last strapped values
        gain_d = gain_q;
        slew_d = slew_q;
        oc_level_d = oc_level_q;
        if (strap_variant_i) begin
            gain_d = gain_strap_i; // R12
            slew_d = slew_strap_i; // R12
            oc_level_d = overcurrent_level_strap_i; // R12
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gain_q <= '0;
            slew_q <= '0;
            oc_level_q <= '0;
        end else if (clk_en_i) begin
            gain_q <= gain_d;
            slew_q <= slew_d;
            oc_level_q <= oc_level_d;
        end
    end

    assign gain_sel_o = gain_q;
    assign slew_sel_o = slew_q;
    assign overcurrent_sel_o = oc_level_q;

    // ==========================================================
    // phase decode and cycle-by-cycle limit
    tpd_gate_type [PHASES-1:0] gate_d;
    tpd_gate_type [PHASES-1:0] gate_q;
    logic [PHASES-1:0] hiz_d;
    logic [PHASES-1:0] hiz_q;
    logic limit_d;
    logic limit_q;

    always_comb begin
        tpd_phase_type st;
        st = PH_HIZ;
        // any amplifier over threshold trips the shared comparator
        limit_d = is_limit_mode(mode_q) && (|sense_over_limit_i); // R9
        for (int p = 0; p < PHASES; p++) begin
            st = decode_phase(mode_q, phase_high_input_i[p], phase_low_input_i[p]); // R18
            gate_d[p].high_on = (st == PH_HIGH) && !limit_d; // R9
            gate_d[p].low_on = (st == PH_LOW);
            hiz_d[p] = (st == PH_HIZ); // R18
            // a tripped limit only cuts the high side, low side keeps its command
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gate_q <= '0;
            hiz_q <= '1;
            limit_q <= 1'h0;
        end else if (clk_en_i) begin
            gate_q <= gate_d;
            hiz_q <= hiz_d;
            limit_q <= limit_d;
        end
    end

    assign gate_o = gate_q;
    assign phase_hiz_o = hiz_q;
    assign current_limit_active_o = limit_q;

    // ==========================================================
    // serial pin drive and fault output
    logic sdo_d;
    logic sdo_q;
    logic sdo_oe_d;
    logic sdo_oe_q;
    logic fault_n_d;
    logic fault_n_q;

    always_comb begin
        sdo_d = serial_data_i;
        sdo_oe_d = 1'h1;
        if (serial_selected(strap_variant_i, serial_chip_select_n_i)) begin // R10
            if (serial_cfg_i.serial_output_drive_select) begin
                sdo_d = serial_data_i; // R11
                sdo_oe_d = 1'h0; // R11
            end else begin
                // open drain: only the low level is driven
                sdo_d = 1'h0; // R11
                sdo_oe_d = serial_data_i; // R11
            end
        end
        fault_n_d = !fault_event_i; // R17
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sdo_q <= 1'h0;
            sdo_oe_q <= 1'h1;
            fault_n_q <= 1'h1;
        end else if (clk_en_i) begin
            sdo_q <= sdo_d;
            sdo_oe_q <= sdo_oe_d;
            fault_n_q <= fault_n_d;
        end
    end

    assign serial_accept_o = serial_selected(strap_variant_i, serial_chip_select_n_i); // R10
    assign serial_data_out_o = sdo_q;
    assign serial_data_oe_o = sdo_oe_q;
    assign fault_output_n_o = fault_n_q;

endmodule : tpd_decode

// ==== tpd_decode_asserts.sv ====
// checker: port-level checks of the pwm decode block
`timescale 1ns/1ps
module tpd_decode_asserts
    import tpd_pkg::*;
#(
    parameter int PHASES = 3
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // watched inputs
    input wire logic strap_variant_i,
    input wire tpd_pkg::tpd_cfg_type serial_cfg_i,
    input wire logic [PHASES-1:0] phase_high_input_i,
    input wire logic [PHASES-1:0] phase_low_input_i,
    input wire logic [PHASES-1:0] sense_over_limit_i,
    input wire logic fault_event_i,
    input wire logic serial_chip_select_n_i,
    // watched outputs
    input wire tpd_pkg::tpd_gate_type [PHASES-1:0] gate_o,
    input wire logic [PHASES-1:0] phase_hiz_o,
    input wire logic reference_limit_is_threshold_o,
    input wire logic sense_amp_output_enable_o,
    input wire logic current_limit_active_o,
    input wire logic [1:0] active_mode_o,
    input wire logic serial_accept_o,
    input wire logic serial_data_oe_o,
    input wire logic fault_output_n_o
);
    // ====================
    // expected gate pairs from the raw inputs
    logic [PHASES-1:0] gate_any;
    logic [1:0] six_want;
    logic [1:0] three_want;
    always_comb begin
        for (int p = 0; p < PHASES; p++) begin
            gate_any[p] = gate_o[p].high_on | gate_o[p].low_on;
        end
    end
    assign six_want = {phase_high_input_i[0] & ~phase_low_input_i[0],
        phase_low_input_i[0] & ~phase_high_input_i[0]};
    assign three_want = {phase_low_input_i[1] & phase_high_input_i[1],
        phase_low_input_i[1] & ~phase_high_input_i[1]};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // ====================
    // checks
    chk_mode_field: assert property (
        clk_en_i && !strap_variant_i |=> active_mode_o == $past(serial_cfg_i.mode))
        else $error("mode field not taken");
    chk_pin_routing: assert property (
        reference_limit_is_threshold_o == active_mode_o[0]
        && sense_amp_output_enable_o != active_mode_o[0]) else $error("limit pin routing wrong");
    chk_six_decode: assert property (
        clk_en_i && active_mode_o == MODE_SIX |=> gate_o[0] == $past(six_want))
        else $error("six-input decode wrong");
    chk_three_decode: assert property (
        clk_en_i && active_mode_o == MODE_THREE |=> gate_o[1] == $past(three_want))
        else $error("three-input decode wrong");
    // only the high side is blanked, low side stays under pwm control
    chk_limit_blank: assert property (
        clk_en_i && active_mode_o[0] && |sense_over_limit_i
        |=> current_limit_active_o && !gate_o[2].high_on) else $error("limit did not blank");
    chk_hiz_gates_off: assert property ((phase_hiz_o & gate_any) == '0)
        else $error("gate on while hi-z");
    chk_serial_accept: assert property (
        serial_accept_o == (!strap_variant_i && !serial_chip_select_n_i))
        else $error("serial accept wrong");
    chk_sdo_release: assert property (
        clk_en_i && (strap_variant_i || serial_chip_select_n_i) |=> serial_data_oe_o)
        else $error("serial output driven while idle");
    chk_fault_follow: assert property (
        clk_en_i |=> fault_output_n_o != $past(fault_event_i)) else $error("fault pin wrong");
    chk_enable_freeze: assert property (
        !clk_en_i |=> $stable(active_mode_o) && $stable(gate_o) && $stable(fault_output_n_o))
        else $error("state moved while clock enable low");
endmodule : tpd_decode_asserts

bind tpd_decode tpd_decode_asserts #(.PHASES(PHASES)) tpd_decode_asserts_inst (
    .clk_i, .reset_n_i, .clk_en_i, .strap_variant_i, .serial_cfg_i, .phase_high_input_i,
    .phase_low_input_i, .sense_over_limit_i, .fault_event_i, .serial_chip_select_n_i, .gate_o,
    .phase_hiz_o, .reference_limit_is_threshold_o, .sense_amp_output_enable_o,
    .current_limit_active_o, .active_mode_o, .serial_accept_o, .serial_data_oe_o,
    .fault_output_n_o
);

// ==== tpd_ctrl_model.sv ====
// partner: controller model driving the pwm inputs and serial select
`timescale 1ns/1ps
module tpd_ctrl_model (
    // clock
    input wire logic clk_i,
    // controller pins
    output logic [2:0] phase_high_input_o,
    output logic [2:0] phase_low_input_o,
    output logic serial_chip_select_n_o,
    output logic serial_data_o
);
    // ====================
    // pin drivers, changed just after falling edges
    initial begin
        phase_high_input_o = 3'h0;
        phase_low_input_o = 3'h0;
        serial_chip_select_n_o = 1'b1;
        serial_data_o = 1'b0;
    end
    task automatic pwm(input logic [2:0] h, input logic [2:0] l);
        @(negedge clk_i);
        phase_high_input_o = h;
        phase_low_input_o = l;
    endtask : pwm
    // all pwm low before a mode change
    task automatic idle();
        pwm(3'h0, 3'h0);
    endtask : idle
    // no hi-z wanted: every low input held high
    task automatic drive3(input logic [2:0] h);
        pwm(h, 3'h7);
    endtask : drive3
    task automatic talk(input logic sel_n, input logic d);
        @(negedge clk_i);
        serial_chip_select_n_o = sel_n;
        serial_data_o = d;
    endtask : talk
endmodule : tpd_ctrl_model

// ==== tb.sv ====
// testbench: directed checks of the pwm decode block
`timescale 1ns/1ps
module tb;
    import tpd_pkg::*;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic strap_variant_i = 1'b0;
    tpd_cfg_type serial_cfg_i = '0;
    logic [1:0] mode_strap_i = 2'h0;
    logic [1:0] buck_voltage_strap_i = 2'h2;
    logic [1:0] gain_strap_i = 2'h1;
    logic [1:0] slew_strap_i = 2'h2;
    logic [1:0] overcurrent_level_strap_i = 2'h3;
    logic [2:0] sense_over_limit_i = 3'h0;
    logic fault_event_i = 1'b0;
    wire logic [2:0] phase_high_input_i;
    wire logic [2:0] phase_low_input_i;
    wire logic serial_chip_select_n_i;
    wire logic serial_data_i;
    tpd_gate_type [2:0] gate_o;
    logic [2:0] phase_hiz_o;
    logic reference_limit_is_threshold_o;
    logic sense_amp_output_enable_o;
    logic current_limit_active_o;
    logic [1:0] active_mode_o;
    logic [1:0] gain_sel_o;
    logic [1:0] slew_sel_o;
    logic [1:0] overcurrent_sel_o;
    tpd_buck_type buck_o;
    logic serial_accept_o;
    logic serial_data_out_o;
    logic serial_data_oe_o;
    logic fault_output_n_o;
    int error_cnt = 0;
    int checks_done = 0;
    always #20 clk_i = ~clk_i;
    tpd_ctrl_model tpd_ctrl_model_inst (.clk_i, .phase_high_input_o(phase_high_input_i),
        .phase_low_input_o(phase_low_input_i), .serial_chip_select_n_o(serial_chip_select_n_i),
        .serial_data_o(serial_data_i));
    tpd_decode #(.PHASES(3)) tpd_decode_inst (.clk_i, .reset_n_i, .clk_en_i, .strap_variant_i,
        .serial_cfg_i, .mode_strap_i, .buck_voltage_strap_i, .gain_strap_i, .slew_strap_i,
        .overcurrent_level_strap_i, .phase_high_input_i, .phase_low_input_i, .sense_over_limit_i,
        .fault_event_i, .serial_chip_select_n_i, .serial_data_i, .gate_o, .phase_hiz_o,
        .reference_limit_is_threshold_o, .sense_amp_output_enable_o, .current_limit_active_o,
        .active_mode_o, .gain_sel_o, .slew_sel_o, .overcurrent_sel_o, .buck_o, .serial_accept_o,
        .serial_data_out_o, .serial_data_oe_o, .fault_output_n_o);
    // ====================
    // helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask : tick
    // gate pair {high_on, low_on} for one phase
    function automatic logic [1:0] want(input logic three, input logic h, input logic l,
            input logic lim);
        logic [1:0] g;
        g = three ? {l & h, l & ~h} : {h & ~l, l & ~h};
        return {g[1] & ~lim, g[0]};
    endfunction : want
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    // ====================
    // tests
    initial begin
        tick(10);
        chk({phase_hiz_o, buck_o}, 8'hf0);
        reset_n_i = 1'b1;
        for (int m = 0; m < 4; m++) begin
            tpd_ctrl_model_inst.idle();
            serial_cfg_i.mode = 2'(m);
            tick(2);
            chk({6'h0, active_mode_o}, 8'(m));
            chk({6'h0, reference_limit_is_threshold_o, sense_amp_output_enable_o},
                m[0] ? 8'h2 : 8'h1);
            for (int v = 0; v < 128; v++) begin
                tpd_ctrl_model_inst.pwm(v[2:0], v[5:3]);
                sense_over_limit_i = {2'h0, v[6]};
                tick(1);
                for (int p = 0; p < 3; p++) begin
                    chk({6'h0, gate_o[p]},
                        {6'h0, want(m[1], v[p], v[p+3], v[6] & m[0])});
                    chk({7'h0, phase_hiz_o[p]},
                        {7'h0, m[1] ? ~v[p+3] : ~(v[p] ^ v[p+3])});
                end
                chk({7'h0, current_limit_active_o}, {7'h0, v[6] & m[0]});
            end
        end
        tpd_ctrl_model_inst.drive3(3'h5);
        sense_over_limit_i = 3'h0;
        tick(1);
        chk({2'h0, gate_o}, 8'h26);
        $display("test decode end");
        tpd_ctrl_model_inst.idle();
        tpd_ctrl_model_inst.talk(1'b0, 1'b1);
        strap_variant_i = 1'b1;
        serial_cfg_i = '1;
        fault_event_i = 1'b1;
        for (int s = 0; s < 4; s++) begin
            mode_strap_i = 2'(s);
            tick(1);
            chk({6'h0, active_mode_o}, 8'(s));
        end
        chk({2'h0, gain_sel_o, slew_sel_o, overcurrent_sel_o}, 8'h1b);
        chk({3'h0, buck_o}, 8'h18);
        chk({6'h0, fault_output_n_o, serial_accept_o}, 8'h0);
        $display("test strap end");
        strap_variant_i = 1'b0;
        for (int k = 0; k < 8; k++) begin
            serial_cfg_i = {2'h0, 2'(k), k[0], k[1], k[2], 1'b0};
            fault_event_i = k[0];
            tick(1);
            chk({3'h0, buck_o}, {3'h0, ~k[0], 2'(k), k[1], k[1] & ~k[2]});
            chk({7'h0, fault_output_n_o}, {7'h0, ~k[0]});
        end
        for (int k = 0; k < 8; k++) begin
            tpd_ctrl_model_inst.talk(k[0], k[1]);
            serial_cfg_i.serial_output_drive_select = k[2];
            tick(1);
            chk({6'h0, serial_accept_o, serial_data_oe_o},
                {6'h0, ~k[0], k[0] | (~k[2] & k[1])});
            if (!k[0]) chk({7'h0, serial_data_out_o}, {7'h0, k[2] & k[1]});
        end
        $display("test serial end");
        clk_en_i = 1'b0;
        serial_cfg_i.mode = MODE_THREE;
        fault_event_i = 1'b0;
        tick(2);
        chk({6'h0, active_mode_o}, {6'h0, MODE_SIX});
        chk({7'h0, fault_output_n_o}, 8'h0);
        clk_en_i = 1'b1;
        tick(1);
        chk({6'h0, active_mode_o}, {6'h0, MODE_THREE});
        chk({7'h0, fault_output_n_o}, 8'h1);
        reset_n_i = 1'b0;
        tick(1);
        chk({phase_hiz_o, buck_o}, 8'hf0);
        chk({5'h0, active_mode_o, fault_output_n_o}, 8'h1);
        reset_n_i = 1'b1;
        tick(2);
        chk({6'h0, active_mode_o}, {6'h0, MODE_THREE});
        $display("test enable and reset end");
        report_and_stop();
    end
endmodule : tb
